// ### tccu_pkg.sv
// Purpose: constants for the timer capture/compare unit
// Assumes: one clk tick per state phase, six phases per machine cycle
// Notes:   register byte address is four times the index below
//
// Operation
// - four 16-bit capture registers load the timer on a selected edge and flag it
// - channel n: bit 2n+1 arms falling edge, bit 2n arms rising edge
// - inputs sampled at first phase; timer copied at end of that cycle
// - capture flags live in the flag register and act as extra external interrupts
// - each timer increment compares the new value with all three compare registers
// - a compare match sets its flag at the end of the following cycle
// - compare 0 match sets port latches whose set-enable bit is one
// - compare 1 match clears port latches whose reset-enable bit is one
// - latches with reset-enable zero are untouched by reset matches
// - each latch's last hardware set or reset is recorded, ignoring software, and reads back in port bits 7..4
// - chip reset clears all three compare registers
// - match-driven latch change reaches the pin at fifth phase of next cycle
// - software port writes appear at the first phase of the next cycle
// - hardware match modification beats a software write in the same cycle
// - simultaneous set and reset of a latch resets it
// - reset-enable bits 3..0 drive pins 5..2; bits 7..4 reserved
// - at 6 MHz overflow period is 65.5, 131, 262 or 524 ms by prescaler
// - mode field: 00 halted, 01 clock div six, 10 test, 11 count pin
// - set-enable bits 3..0 drive pins 5..2 on compare match
// - comparator flags are set in the sixth phase of the cycle after a match
// - compare 2 match only sets a polled flag, never an interrupt request
package tccu_pkg;
	localparam logic [2:0] PH_S1 = 3'h0;
	localparam logic [2:0] PH_S2 = 3'h1;
	localparam logic [2:0] PH_S5 = 3'h4;
	localparam logic [2:0] PH_S6 = 3'h5;

	// register indices; byte address = index * 4
	localparam logic [7:0] IDX_FLAGS    = 8'hc8;
	localparam logic [7:0] IDX_CTRL     = 8'hea;
	localparam logic [7:0] IDX_EDGE_SEL = 8'heb;
	localparam logic [7:0] IDX_SET_EN   = 8'hee;
	localparam logic [7:0] IDX_RST_EN   = 8'hef;
	localparam logic [7:0] IDX_TMR_LO   = 8'ha0;
	localparam logic [7:0] IDX_TMR_HI   = 8'ha1;
	localparam logic [7:0] IDX_CAP_BASE = 8'ha2;
	localparam logic [7:0] IDX_CMP_BASE = 8'haa;
	localparam logic [7:0] IDX_PORT     = 8'hb0;

	// control fields
	localparam int CTRL_WORD_IRQ_SEL = 7;
	localparam int CTRL_BYTE_IRQ_SEL = 6;
	localparam int CTRL_EXT_RST_EN   = 5;
	localparam int CTRL_BYTE_OVF     = 4;
	localparam int CTRL_PRESC_HI     = 3;
	localparam int CTRL_PRESC_LO     = 2;
	localparam int CTRL_MODE_HI      = 1;
	localparam int CTRL_MODE_LO      = 0;

	// flag fields
	localparam int FLG_WORD_OVF = 7;
	localparam int FLG_CMP_BASE = 4;

	localparam logic [1:0] MODE_HALT = 2'h0;
	localparam logic [1:0] MODE_DIV6 = 2'h1;
	localparam logic [1:0] MODE_TEST = 2'h2;
	localparam logic [1:0] MODE_PIN  = 2'h3;

	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] ENABLE_MASK = 8'h0f;

	// overflow periods at a 6 MHz oscillator, in microseconds, per prescaler ratio
	localparam int OVF_US_DIV1 = 65536;
	localparam int OVF_US_DIV8 = 524288;
endpackage

// ### tccu_top.sv
// Purpose: capture/compare logic around a 16-bit timer, with AHB-Lite register access
// Assumes: single-word AHB transfers; inputs synchronous to clk
// Notes:   zero wait states; hrdata is registered at the address phase
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module tccu_top (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [3:0]  capture_in,
	input  wire logic        count_pin,
	input  wire logic        timer_reset_pin,
	output logic      [3:0]  port_pins,
	output logic      [3:0]  capture_irq,
	output logic      [1:0]  compare_irq
);
	import tccu_pkg::*;

	logic [2:0]  phase_reg;
	logic        cyc_end;
	logic        wr_pend_reg;
	logic [7:0]  wr_idx_reg;
	logic [7:0]  wdat;
	logic [31:0] hrdata_reg;
	logic        hready_reg;
	logic [7:0]  ctrl_reg;
	logic [7:0]  edge_sel_reg;
	logic [7:0]  set_en_reg;
	logic [7:0]  rst_en_reg;
	logic [7:0]  flags_reg;
	logic [15:0] timer_reg;
	logic [15:0] cap_reg [4];
	logic [15:0] cmp_reg [3];
	logic [3:0]  cap_smp_reg;
	logic [3:0]  cap_hit_reg;
	logic [3:0]  cap_hit;
	logic        pin_s2_reg;
	logic        pin_s5_reg;
	logic        ext_edge_reg;
	logic        rt_smp_reg;
	logic        timer_clear;
	logic [2:0]  presc_reg;
	logic [2:0]  presc_mask;
	logic        src_tick;
	logic        tick;
	logic        inc_done_reg;
	logic [2:0]  match_reg;
	logic [2:0]  act_reg;
	logic [3:0]  port_reg;
	logic [3:0]  last_set_reg;
	logic [3:0]  sw_mask_reg;
	logic [3:0]  sw_val_reg;
	logic [3:0]  hw_set;
	logic [3:0]  hw_clr;
	logic [7:0]  rd_data;
	logic [7:0]  rd_idx;

	assign cyc_end = (phase_reg == PH_S6);
	assign wdat    = hwdata[7:0];
	assign rd_idx  = haddr[9:2];

	function automatic logic wr_hit(input logic [7:0] idx);
		wr_hit = wr_pend_reg && (wr_idx_reg == idx);
	endfunction

	// ============================================================
	// machine cycle phases
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_reg <= PH_S1;
		end else if (cyc_end) begin
			phase_reg <= PH_S1;
		end else begin
			phase_reg <= phase_reg + 3'h1;
		end
	end

	// ============================================================
	// AHB-Lite slave
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 8'h00;
			hrdata_reg  <= 32'h0000_0000;
			hready_reg  <= 1'b0;
		end else begin
			hready_reg  <= 1'b1;
			wr_pend_reg <= hsel && htrans[1] && hwrite && hready;
			if (hsel && htrans[1] && hready) begin
				wr_idx_reg <= rd_idx;
				if (!hwrite) begin
					hrdata_reg <= {24'h00_0000, rd_data};
				end
			end
		end
	end

	// unmapped indices read as zero and ignore writes
	always_comb begin
		rd_data = 8'h00;
		unique case (rd_idx)
			IDX_FLAGS:       rd_data = flags_reg;
			IDX_CTRL:        rd_data = ctrl_reg;
			IDX_EDGE_SEL:    rd_data = edge_sel_reg;
			IDX_SET_EN:      rd_data = set_en_reg;
			IDX_RST_EN:      rd_data = rst_en_reg;
			IDX_TMR_LO:      rd_data = timer_reg[7:0];
			IDX_TMR_HI:      rd_data = timer_reg[15:8];
			IDX_CAP_BASE:    rd_data = cap_reg[0][7:0];
			IDX_CAP_BASE+8'h1: rd_data = cap_reg[0][15:8];
			IDX_CAP_BASE+8'h2: rd_data = cap_reg[1][7:0];
			IDX_CAP_BASE+8'h3: rd_data = cap_reg[1][15:8];
			IDX_CAP_BASE+8'h4: rd_data = cap_reg[2][7:0];
			IDX_CAP_BASE+8'h5: rd_data = cap_reg[2][15:8];
			IDX_CAP_BASE+8'h6: rd_data = cap_reg[3][7:0];
			IDX_CAP_BASE+8'h7: rd_data = cap_reg[3][15:8];
			IDX_CMP_BASE:      rd_data = cmp_reg[0][7:0];
			IDX_CMP_BASE+8'h1: rd_data = cmp_reg[0][15:8];
			IDX_CMP_BASE+8'h2: rd_data = cmp_reg[1][7:0];
			IDX_CMP_BASE+8'h3: rd_data = cmp_reg[1][15:8];
			IDX_CMP_BASE+8'h4: rd_data = cmp_reg[2][7:0];
			IDX_CMP_BASE+8'h5: rd_data = cmp_reg[2][15:8];
			IDX_PORT:        rd_data = {last_set_reg, port_reg};
			default:         rd_data = 8'h00;
		endcase
	end

	// ============================================================
	// configuration registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			edge_sel_reg <= CTRL_RESET;
			set_en_reg   <= CTRL_RESET;
			rst_en_reg   <= CTRL_RESET;
		end else begin
			if (wr_hit(IDX_EDGE_SEL)) begin
				edge_sel_reg <= wdat;
			end
			if (wr_hit(IDX_SET_EN)) begin
				set_en_reg <= wdat & ENABLE_MASK;
			end
			if (wr_hit(IDX_RST_EN)) begin
				rst_en_reg <= wdat & ENABLE_MASK;
			end
		end
	end

	// byte overflow flag sits in control; a set in the clearing cycle survives
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wr_hit(IDX_CTRL)) begin
			ctrl_reg <= wdat;
			if (tick && cyc_end && (timer_reg[7:0] == 8'hff)) begin
				ctrl_reg[CTRL_BYTE_OVF] <= 1'b1;
			end
		end else if (tick && cyc_end && (timer_reg[7:0] == 8'hff)) begin
			ctrl_reg[CTRL_BYTE_OVF] <= 1'b1;
		end
	end

	// ============================================================
	// timer source, prescaler and counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_s2_reg   <= 1'b0;
			pin_s5_reg   <= 1'b0;
			ext_edge_reg <= 1'b0;
			rt_smp_reg   <= 1'b0;
		end else begin
			if (phase_reg == PH_S2) begin
				pin_s2_reg <= count_pin;
				if (count_pin && !pin_s5_reg) begin
					ext_edge_reg <= 1'b1;
				end
			end
			if (phase_reg == PH_S5) begin
				pin_s5_reg <= count_pin;
				if (count_pin && !pin_s2_reg) begin
					ext_edge_reg <= 1'b1;
				end
			end
			if (cyc_end) begin
				ext_edge_reg <= 1'b0;
			end
			if (phase_reg == PH_S1) begin
				rt_smp_reg <= timer_reset_pin;
			end
		end
	end

	assign timer_clear = ctrl_reg[CTRL_EXT_RST_EN] && (phase_reg == PH_S1) && timer_reset_pin && !rt_smp_reg;

	always_comb begin
		unique case (ctrl_reg[CTRL_MODE_HI:CTRL_MODE_LO])
			MODE_DIV6: src_tick = 1'b1;
			MODE_PIN:  src_tick = ext_edge_reg;
			MODE_HALT: src_tick = 1'b0;
			MODE_TEST: src_tick = 1'b0;
		endcase
	end

	// ratio 1, 2, 4 or 8 sets the overflow period in multiples of OVF_US_DIV1
	assign presc_mask = {ctrl_reg[CTRL_PRESC_HI] && ctrl_reg[CTRL_PRESC_LO],
		ctrl_reg[CTRL_PRESC_HI], ctrl_reg[CTRL_PRESC_HI] || ctrl_reg[CTRL_PRESC_LO]};
	assign tick = src_tick && ((presc_reg & presc_mask) == presc_mask);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			presc_reg <= 3'h0;
		end else if (timer_clear || (wr_hit(IDX_CTRL) && (wdat[3:0] != ctrl_reg[3:0]))) begin
			presc_reg <= 3'h0;
		end else if (cyc_end && src_tick) begin
			presc_reg <= (presc_reg + 3'h1) & presc_mask;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_reg    <= 16'h0000;
			inc_done_reg <= 1'b0;
		end else begin
			if (timer_clear) begin
				timer_reg <= 16'h0000;
			end else if (cyc_end && tick) begin
				timer_reg <= timer_reg + 16'h0001;
			end
			if (cyc_end) begin
				inc_done_reg <= tick;
			end
		end
	end

	// ============================================================
	// capture channels
	generate
		for (genvar n = 0; n < 4; n++) begin : g_cap
			// a channel with both select bits clear never hits
			assign cap_hit[n] = (edge_sel_reg[2*n] && capture_in[n] && !cap_smp_reg[n]) ||
				(edge_sel_reg[2*n+1] && !capture_in[n] && cap_smp_reg[n]);

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					cap_smp_reg[n] <= 1'b0;
					cap_hit_reg[n] <= 1'b0;
					cap_reg[n]     <= 16'h0000;
				end else begin
					if (phase_reg == PH_S1) begin
						cap_smp_reg[n] <= capture_in[n];
						cap_hit_reg[n] <= cap_hit[n];
					end
					if (cyc_end && cap_hit_reg[n]) begin
						cap_reg[n] <= timer_reg;
					end
				end
			end
		end
	endgenerate

	// ============================================================
	// compare channels
	generate
		for (genvar m = 0; m < 3; m++) begin : g_cmp
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					cmp_reg[m] <= 16'h0000;
				end else begin
					if (wr_hit(IDX_CMP_BASE + 8'(2*m))) begin
						cmp_reg[m][7:0] <= wdat;
					end
					if (wr_hit(IDX_CMP_BASE + 8'(2*m+1))) begin
						cmp_reg[m][15:8] <= wdat;
					end
				end
			end
		end
	endgenerate

	// match cycle follows the increment; action lands in the cycle after that
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			match_reg <= 3'h0;
			act_reg   <= 3'h0;
		end else begin
			if (phase_reg == PH_S1 && inc_done_reg) begin
				match_reg <= {timer_reg == cmp_reg[2], timer_reg == cmp_reg[1],
					timer_reg == cmp_reg[0]};
			end
			if (cyc_end) begin
				act_reg   <= match_reg;
				match_reg <= 3'h0;
			end
		end
	end

	// ============================================================
	// flags: hardware set wins over a software write in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_reg <= 8'h00;
		end else begin
			if (wr_hit(IDX_FLAGS)) begin
				flags_reg <= wdat;
			end
			if (cyc_end) begin
				for (int i = 0; i < 4; i++) begin
					if (cap_hit_reg[i]) begin
						flags_reg[i] <= 1'b1;
					end
				end
				for (int j = 0; j < 3; j++) begin
					if (act_reg[j]) begin
						flags_reg[FLG_CMP_BASE + j] <= 1'b1;
					end
				end
				if (tick && (timer_reg == 16'hffff)) begin
					flags_reg[FLG_WORD_OVF] <= 1'b1;
				end
			end
		end
	end

	// ============================================================
	// port latches
	assign hw_clr = act_reg[1] ? rst_en_reg[3:0] : 4'h0;
	assign hw_set = act_reg[0] ? (set_en_reg[3:0] & ~hw_clr) : 4'h0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_reg     <= 4'h0;
			last_set_reg <= 4'h0;
			sw_mask_reg  <= 4'h0;
			sw_val_reg   <= 4'h0;
		end else begin
			if (wr_hit(IDX_PORT)) begin
				sw_mask_reg <= 4'hf;
				sw_val_reg  <= wdat[3:0];
			end
			if (phase_reg == PH_S1) begin
				port_reg    <= (port_reg & ~sw_mask_reg) | (sw_val_reg & sw_mask_reg);
				sw_mask_reg <= wr_hit(IDX_PORT) ? 4'hf : 4'h0;
			end
			if (phase_reg == PH_S5) begin
				port_reg <= (port_reg | hw_set) & ~hw_clr;
				// software changes pending on touched bits are discarded
				sw_mask_reg <= (wr_hit(IDX_PORT) ? 4'hf : sw_mask_reg) & ~(hw_set | hw_clr);
				// sequence memory ignores software; it records which latches were last set by hardware
				last_set_reg <= (last_set_reg | hw_set) & ~hw_clr;
			end
		end
	end

	// ============================================================
	// outputs
	assign hrdata      = hrdata_reg;
	assign hreadyout   = hready_reg;
	assign hresp       = 1'b0;
	assign port_pins   = port_reg;
	assign capture_irq = flags_reg[3:0];
	assign compare_irq = flags_reg[FLG_CMP_BASE+1:FLG_CMP_BASE];
endmodule

// ### tccu_properties.sv
// Purpose: port assertions for the timer capture/compare unit
// Assumes: helper phase count matches the design, first phase at reset release
// Notes:   flag rises assume software writes only zeros to the flag register
`timescale 1ns/1ps
module tccu_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [3:0]  capture_in,
	input wire logic        count_pin,
	input wire logic        timer_reset_pin,
	input wire logic [3:0]  port_pins,
	input wire logic [3:0]  capture_irq,
	input wire logic [1:0]  compare_irq
);
	import tccu_pkg::*;
	logic [2:0] ph_reg;
	// ====
	// phase count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ph_reg <= PH_S1;
		end else begin
			ph_reg <= (ph_reg == PH_S6) ? PH_S1 : ph_reg + 3'h1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// ====
	// properties
	a_ready_after_rst: assert property (!$past(rst) |-> hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	a_zero_wait: assert property (hsel && htrans[1] && hready |=> hreadyout)
		else $error("wait state inserted");
	a_rdata_byte: assert property (hrdata[31:8] == 24'h0)
		else $error("hrdata upper bits set");
	a_port_phase: assert property ($changed(port_pins) |-> ph_reg == PH_S6 || ph_reg == PH_S2)
		else $error("port change off phase");
	a_flag_phase: assert property (({compare_irq, capture_irq} & ~$past({compare_irq, capture_irq})) != 6'h0
		|-> ph_reg == PH_S1) else $error("flag set off phase");
	// a new capture flag needs a level change between the two last first-phase samples
	a_capture_cause: assert property ((capture_irq & ~$past(capture_irq)
		& ~($past(capture_in, 6) ^ $past(capture_in, 12))) == 4'h0) else $error("capture without edge");
	a_port_then_flag: assert property ($changed(port_pins) && ph_reg == PH_S6 |=> compare_irq != 2'h0)
		else $error("match without flag");
	c_port_hw: cover property ($changed(port_pins) && ph_reg == PH_S6);
	c_capture: cover property ($rose(|capture_irq));
	c_compare: cover property ($rose(compare_irq[1]));
endmodule
bind tccu_top tccu_checker i_tccu_checker (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
	.hrdata, .hreadyout, .hresp, .capture_in, .count_pin, .timer_reset_pin, .port_pins, .capture_irq, .compare_irq);

// ### tccu_partner.sv
// Purpose: far-side model of the capture inputs and timer pins
// Assumes: levels change just after a rising clk edge
// Notes:   count and timer-reset pins stay low; only the internal timer clock is used
`timescale 1ns/1ps
module tccu_partner (
	input  wire logic       clk,
	output logic      [3:0] capture_in,
	output logic            count_pin,
	output logic            timer_reset_pin
);
	initial begin
		capture_in = 4'h0;
		count_pin = 1'b0;
		timer_reset_pin = 1'b0;
	end
	// held over two machine cycles so a first-phase sample always sees the level
	task automatic drive_events(input logic [3:0] v, input int hold);
		@(posedge clk);
		capture_in <= v;
		repeat (hold) @(posedge clk);
	endtask
endmodule

// ### tb.sv
// Purpose: self-checking bench for the timer capture/compare unit
// Assumes: zero-wait register bus; timer counts once per six clk in divide-by-six mode
// Notes:   expectations come from a register image and a timer count kept here
`timescale 1ns/1ps
module tb;
	import tccu_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic        hreadyout, hresp, count_pin, timer_reset_pin;
	logic [3:0]  capture_in, port_pins, capture_irq, exp4;
	logic [1:0]  compare_irq;
	logic [7:0]  mdl [256];
	logic [7:0]  es;
	logic [7:0]  regs [8] = '{IDX_FLAGS, IDX_CTRL, IDX_EDGE_SEL, IDX_SET_EN, IDX_RST_EN, IDX_TMR_LO, IDX_TMR_HI, 8'h01};
	logic [7:0]  cmpv [6] = '{8'h03, 8'h00, 8'h06, 8'h00, 8'h04, 8'h00};
	logic [1:0]  modes [4] = '{MODE_HALT, MODE_TEST, MODE_PIN, MODE_DIV6};
	int          errors = 0;
	int          num_checks = 0;
	int          tmr = 0;

	always #4 clk = ~clk;

	tccu_top i_tccu_top (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .capture_in, .count_pin, .timer_reset_pin, .port_pins, .capture_irq,
		.compare_irq);
	tccu_partner i_tccu_partner (.clk, .capture_in, .count_pin, .timer_reset_pin);

	// ====
	// reporting
	task automatic results();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	// ====
	// bus master
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			errors++;
			results();
		end
	endtask

	task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'h0};
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		wait_ready();
		rd = hrdata;
	endtask

	task automatic put(input logic [7:0] idx, input logic [7:0] v, input logic [7:0] m);
		mdl[idx] = v & m;
		bus(idx, 1'b1, v);
	endtask

	task automatic rchk(input logic [7:0] idx);
		bus(idx, 1'b0, 8'h0);
		check(rd, {24'h0, mdl[idx]});
	endtask

	task automatic rall();
		foreach (regs[i]) rchk(regs[i]);
		for (int i = 0; i < 6; i++) rchk(8'(IDX_CMP_BASE + i));
	endtask

	// whole machine cycles between the two control writes, so the count is exact
	task automatic run(input int n, input logic [1:0] m);
		put(IDX_CTRL, {6'h0, m}, 8'hff);
		repeat (6 * n - 2) @(posedge clk);
		put(IDX_CTRL, 8'h00, 8'hff);
		if (m == MODE_DIV6) tmr += n;
		mdl[IDX_TMR_LO] = tmr[7:0];
		mdl[IDX_TMR_HI] = tmr[15:8];
		repeat (16) @(posedge clk);
		rchk(IDX_TMR_LO);
	endtask

	// ====
	// scenarios
	initial begin
		void'($urandom(32'h44a5));
		foreach (mdl[i]) mdl[i] = 8'h0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check({26'h0, port_pins, capture_irq, compare_irq}, 32'h0);
		rall();
		for (int i = 0; i < 6; i++) put(8'(IDX_CMP_BASE + i), 8'($urandom), 8'hff);
		put(IDX_SET_EN, 8'($urandom), ENABLE_MASK);
		put(IDX_RST_EN, 8'($urandom), ENABLE_MASK);
		put(8'h01, 8'h5a, 8'h00);
		rall();
		es = 8'($urandom);
		foreach (cmpv[i]) put(8'(IDX_CMP_BASE + i), cmpv[i], 8'hff);
		put(IDX_SET_EN, 8'hff, ENABLE_MASK);
		put(IDX_RST_EN, es, ENABLE_MASK);
		foreach (modes[i]) run(3, modes[i]);
		run(5, MODE_DIV6);
		check({28'h0, port_pins}, {28'h0, ~es[3:0]});
		mdl[IDX_FLAGS] = 8'h70;
		rchk(IDX_FLAGS);
		check({30'h0, compare_irq}, 32'h3);
		put(IDX_FLAGS, 8'h00, 8'hff);
		put(IDX_PORT, 8'h0f, 8'h00);
		repeat (8) @(posedge clk);
		check({28'h0, port_pins}, 32'hf);
		mdl[IDX_PORT] = {~es[3:0], 4'hf};
		rchk(IDX_PORT);
		put(IDX_RST_EN, 8'h0f, ENABLE_MASK);
		put(IDX_CMP_BASE, 8'(tmr + 2), 8'hff);
		put(8'(IDX_CMP_BASE + 2), 8'(tmr + 2), 8'hff);
		run(3, MODE_DIV6);
		check({28'h0, port_pins}, 32'h0);
		mdl[IDX_PORT] = 8'h00;
		rchk(IDX_PORT);
		for (int k = 0; k < 4; k++) begin
			es = (k == 0) ? 8'h00 : 8'($urandom);
			put(IDX_EDGE_SEL, es, 8'hff);
			put(IDX_FLAGS, 8'h00, 8'hff);
			run(k + 1, MODE_DIV6);
			for (int e = 0; e < 2; e++) begin
				i_tccu_partner.drive_events((e == 0) ? 4'hf : 4'h0, 14);
				for (int n = 0; n < 4; n++) begin
					exp4[n] = es[2 * n + e];
					if (exp4[n]) begin
						mdl[8'(IDX_CAP_BASE + 2 * n)] = tmr[7:0];
						mdl[8'(IDX_CAP_BASE + 2 * n + 1)] = tmr[15:8];
					end
				end
				check({28'h0, capture_irq}, {28'h0, exp4});
				put(IDX_FLAGS, 8'h00, 8'hff);
			end
			for (int n = 0; n < 8; n++) rchk(8'(IDX_CAP_BASE + n));
		end
		results();
	end
endmodule
